// file: hdl/aec_pkg.sv
// aec_pkg: register map, field layout and timing constants of the bus error capture block
package aec_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] AEC_OFS_STATUS = 8'h50;
    localparam logic [7:0] AEC_OFS_ADDR   = 8'h54;
    localparam logic [7:0] AEC_OFS_WDATA  = 8'h58;
    localparam logic [7:0] AEC_OFS_RDATA  = 8'h5C;
    localparam logic [7:0] AEC_OFS_ATTR   = 8'h60;

    // ****************************************
    // status bit positions
    // ****************************************
    localparam int AEC_ST_ERR  = 0;
    localparam int AEC_ST_OVF  = 1;
    localparam int AEC_ST_WDOG = 2;

    // ****************************************
    // attribute field layout
    // ****************************************
    localparam int AEC_AT_MASTER_LSB = 0;
    localparam int AEC_AT_WRITE      = 4;
    localparam int AEC_AT_SIZE_LSB   = 5;
    localparam int AEC_AT_TRANS_LSB  = 7;
    localparam int AEC_AT_BURST_LSB  = 9;

    // ****************************************
    // bus codes and reset values
    // ****************************************
    localparam logic [1:0]  AEC_HRESP_ERROR = 2'h1;
    localparam logic [1:0]  AEC_HTRANS_IDLE = 2'h0;
    localparam logic [1:0]  AEC_HTRANS_BUSY = 2'h1;
    localparam logic [31:0] AEC_ZERO32      = 32'h0000_0000;
    localparam logic [11:0] AEC_ZERO12      = 12'h000;

    // ****************************************
    // timing
    // ****************************************
    localparam int AEC_CLK_MHZ       = 200;
    localparam int AEC_WDOG_TIME_US  = 10;
    localparam int AEC_WDOG_CYCLES   = AEC_WDOG_TIME_US * AEC_CLK_MHZ;
    localparam int AEC_WDOG_W        = 16;

endpackage

// file: hdl/aec_watchdog.sv
// aec_watchdog: counts wait states of an outstanding transfer and flags a hung bus
`timescale 1ns/1ps

module aec_watchdog
    import aec_pkg::*;
#(
    parameter int LIMIT = AEC_WDOG_CYCLES
) (
    input  wire logic clk,       // system clock
    input  wire logic rst_b,     // async reset, active low
    input  wire logic busy,      // data phase outstanding, no response yet
    output logic      expire     // one-cycle pulse at limit
);

    logic [AEC_WDOG_W-1:0] cnt_q;
    logic [AEC_WDOG_W-1:0] cnt_d;
    logic                  expire_q;
    logic                  expire_d;

    localparam logic [AEC_WDOG_W-1:0] LIM = AEC_WDOG_W'(LIMIT - 1);

    always_comb begin
        cnt_d    = cnt_q;
        expire_d = 1'b0;
        if (!busy) begin
            cnt_d = '0;
        end else if (cnt_q == LIM) begin
            // restart so a bus hung for long keeps reporting, feeding overflow
            expire_d = 1'b1;
            cnt_d    = '0;
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q    <= '0;
            expire_q <= 1'b0;
        end else begin
            cnt_q    <= cnt_d;
            expire_q <= expire_d;
        end
    end

    assign expire = expire_q;

endmodule // aec_watchdog

// file: hdl/aec_regread.sv
// aec_regread: read multiplexer for the capture registers
`timescale 1ns/1ps

module aec_regread
    import aec_pkg::*;
(
    input  wire logic [7:0]  addr,    // register offset
    input  wire logic [2:0]  status,  // status bits
    input  wire logic [31:0] cap_a,   // captured address
    input  wire logic [31:0] cap_w,   // captured write data
    input  wire logic [31:0] cap_r,   // captured read data
    input  wire logic [11:0] cap_t,   // captured attributes
    output logic      [31:0] rdata    // read value
);

    always_comb begin
        rdata = AEC_ZERO32;
        unique case (addr)
            AEC_OFS_STATUS: rdata = {29'h0000_0000, status};
            AEC_OFS_ADDR:   rdata = cap_a;
            AEC_OFS_WDATA:  rdata = cap_w;
            AEC_OFS_RDATA:  rdata = cap_r;
            AEC_OFS_ATTR:   rdata = {20'h0_0000, cap_t};
            default:        rdata = AEC_ZERO32;
        endcase
    end

endmodule // aec_regread

// file: hdl/aec_top.sv
// aec_top: bus error monitor capturing the first failing transfer
`timescale 1ns/1ps

// Function
// - error status bit sets on any bus error, zero when none seen since clear
// - writing one to error bit clears whole status; zero does nothing
// - overflow sets when further errors arrive before software clears
// - overflow bit is not written directly; only the error bit clear zeroes it
// - captured values stay those of the first error; later ones only flag overflow
// - cause bit reads zero for explicit error response
// - watchdog expiry without response is an error, cause bit one
// - overflow and cause reset to zero, bits 31:3 reserved
// - full 32-bit failing address captured read only
// - write data captured at offset 0x58
// - read data captured at offset 0x5C
// - master number captured in attribute bits 3:0
// - write direction captured in attribute bit 4
// - size captured in attribute bits 6:5
// - transfer type captured in attribute bits 8:7
// - burst type in bits 11:9, bits 31:12 reserved
// - captured state survives warm reset, cleared only by cold reset
module aec_top
    import aec_pkg::*;
#(
    parameter int WDOG_CYCLES = AEC_WDOG_CYCLES
) (
    input  wire logic        clk,        // system clock, 200 MHz
    input  wire logic        rst_b,      // cold reset, async, active low
    input  wire logic        warm_rst,   // warm reset, capture unaffected
    input  wire logic [31:0] haddr,      // bus address phase
    input  wire logic [1:0]  htrans,     // transfer type
    input  wire logic        hwrite,     // direction
    input  wire logic [2:0]  hsize,      // size
    input  wire logic [2:0]  hburst,     // burst type
    input  wire logic [3:0]  hmaster,    // current master
    input  wire logic        hready,     // transfer done
    input  wire logic [1:0]  hresp,      // response
    input  wire logic [31:0] hwdata,     // write data
    input  wire logic [31:0] hrdata,     // read data
    input  wire logic        reg_sel,    // register access strobe
    input  wire logic        reg_wr,     // 1 write, 0 read
    input  wire logic [7:0]  reg_addr,   // register offset
    input  wire logic [31:0] reg_wdata,  // register write data
    output logic      [31:0] reg_rdata,  // register read data, one cycle later
    output logic             err_flag    // error recorded
);

    // ****************************************
    // decode helpers
    // ****************************************
    // nonseq or seq only; busy and idle never get a data phase of their own
    function automatic logic opens_data(input logic [1:0] trans);
        opens_data = (trans != AEC_HTRANS_IDLE) && (trans != AEC_HTRANS_BUSY);
    endfunction

    // anything but idle puts a real address on the bus
    function automatic logic carries_attr(input logic [1:0] trans);
        carries_attr = (trans != AEC_HTRANS_IDLE);
    endfunction

    // fields placed by position so the layout lives in one spot
    function automatic logic [11:0] pack_attr(
        input logic [2:0] burst,
        input logic [1:0] trans,
        input logic [1:0] size,
        input logic       wr,
        input logic [3:0] mst
    );
        logic [11:0] v;
        v                         = AEC_ZERO12;
        v[AEC_AT_MASTER_LSB +: 4] = mst;
        v[AEC_AT_WRITE]           = wr;
        v[AEC_AT_SIZE_LSB +: 2]   = size;
        v[AEC_AT_TRANS_LSB +: 2]  = trans;
        v[AEC_AT_BURST_LSB +: 3]  = burst;
        return v;
    endfunction

    // ****************************************
    // data phase tracking
    // ****************************************
    logic        dp_q;
    logic        dp_d;
    logic [31:0] dp_addr_q;
    logic [31:0] dp_addr_d;
    logic [11:0] dp_attr_q;
    logic [11:0] dp_attr_d;
    logic        wd_exp;

    always_comb begin
        dp_d      = dp_q;
        dp_addr_d = dp_addr_q;
        dp_attr_d = dp_attr_q;
        if (hready) begin
            dp_d = opens_data(htrans);
            if (carries_attr(htrans)) begin
                dp_addr_d = haddr;
                dp_attr_d = pack_attr(hburst, htrans, hsize[1:0], hwrite, hmaster);
            end
        end
        if (warm_rst) begin
            dp_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dp_q      <= 1'b0;
            dp_addr_q <= AEC_ZERO32;
            dp_attr_q <= AEC_ZERO12;
        end else begin
            dp_q      <= dp_d;
            dp_addr_q <= dp_addr_d;
            dp_attr_q <= dp_attr_d;
        end
    end

    aec_watchdog #(
        .LIMIT (WDOG_CYCLES)
    ) u_wdog (
        .clk    (clk),
        .rst_b  (rst_b),
        .busy   (dp_q && !hready),
        .expire (wd_exp)
    );

    // ****************************************
    // error detection and capture
    // ****************************************
    // first cycle of a two-cycle error response
    logic resp_err;
    logic any_err;
    logic clr_wr;
    assign resp_err = dp_q && !hready && (hresp == AEC_HRESP_ERROR);
    assign any_err  = resp_err || wd_exp;
    assign clr_wr   = reg_sel && reg_wr && (reg_addr == AEC_OFS_STATUS)
                      && reg_wdata[AEC_ST_ERR];

    logic [2:0]  st_q;
    logic [2:0]  st_d;
    logic [31:0] cap_a_q;
    logic [31:0] cap_a_d;
    logic [31:0] cap_w_q;
    logic [31:0] cap_w_d;
    logic [31:0] cap_r_q;
    logic [31:0] cap_r_d;
    logic [11:0] cap_t_q;
    logic [11:0] cap_t_d;

    always_comb begin
        st_d    = st_q;
        cap_a_d = cap_a_q;
        cap_w_d = cap_w_q;
        cap_r_d = cap_r_q;
        cap_t_d = cap_t_q;
        // writes only reach the status through the clear, which zeroes overflow too
        if (clr_wr) begin
            st_d = 3'h0;
        end
        // an error in the clear cycle wins and is recorded fresh
        if (any_err) begin
            if (st_q[AEC_ST_ERR] && !clr_wr) begin
                st_d[AEC_ST_OVF] = 1'b1;
            end else begin
                st_d[AEC_ST_ERR]  = 1'b1;
                st_d[AEC_ST_OVF]  = 1'b0;
                st_d[AEC_ST_WDOG] = wd_exp && !resp_err;
                cap_a_d = dp_addr_q;
                cap_w_d = hwdata;
                cap_r_d = hrdata;
                cap_t_d = dp_attr_q;
            end
        end
    end

    // only the cold reset touches captured state; warm_rst is ignored here
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q    <= 3'h0;
            cap_a_q <= AEC_ZERO32;
            cap_w_q <= AEC_ZERO32;
            cap_r_q <= AEC_ZERO32;
            cap_t_q <= AEC_ZERO12;
        end else begin
            st_q    <= st_d;
            cap_a_q <= cap_a_d;
            cap_w_q <= cap_w_d;
            cap_r_q <= cap_r_d;
            cap_t_q <= cap_t_d;
        end
    end

    // ****************************************
    // register read port
    // ****************************************
    logic [31:0] rd_mux;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        flag_q;

    aec_regread u_rd (
        .addr   (reg_addr),
        .status (st_q),
        .cap_a  (cap_a_q),
        .cap_w  (cap_w_q),
        .cap_r  (cap_r_q),
        .cap_t  (cap_t_q),
        .rdata  (rd_mux)
    );

    always_comb begin
        rdata_d = rdata_q;
        if (reg_sel && !reg_wr) begin
            rdata_d = rd_mux;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= AEC_ZERO32;
            flag_q  <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            flag_q  <= st_d[AEC_ST_ERR];
        end
    end

    assign reg_rdata = rdata_q;
    assign err_flag  = flag_q;

endmodule // aec_top

// file: test/aec_monitor.sv
// aec_monitor: port-level checks of the bus error capture block
`timescale 1ns/1ps
module aec_monitor
    import aec_pkg::*;
#(
    parameter int WDOG_CYCLES = 8 // hang8 below assumes 8
) (
    input wire logic        clk,       // clock
    input wire logic        rst_b,     // cold reset
    input wire logic        hready,    // bus ready
    input wire logic [1:0]  htrans,    // transfer type
    input wire logic [1:0]  hresp,     // response
    input wire logic        reg_sel,   // access strobe
    input wire logic        reg_wr,    // write
    input wire logic [7:0]  reg_addr,  // offset
    input wire logic [31:0] reg_wdata, // write data
    input wire logic [31:0] reg_rdata, // read data
    input wire logic        err_flag   // error recorded
);
    logic clr_w;
    assign clr_w = reg_sel && reg_wr && reg_addr == AEC_OFS_STATUS && reg_wdata[0];
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence addr_ph; htrans[1] && hready; endsequence
    sequence err_cyc; addr_ph ##1 (!hready && hresp == AEC_HRESP_ERROR); endsequence
    sequence hang8; addr_ph ##1 (!hready && hresp == 2'h0) [*8]; endsequence
    resp_err_a: assert property (err_cyc |=> err_flag)
        else $error("error response missed");
    wdog_err_a: assert property (hang8 |-> ##[1:2] err_flag)
        else $error("hang missed");
    st_clear_a: assert property (clr_w && hready |=> !err_flag)
        else $error("clear failed");
    // hready high rules out a new error response in the same cycle
    wr_zero_a: assert property (reg_sel && reg_wr && !reg_wdata[0]
        && hready |=> $stable(err_flag)) else $error("zero write changed status");
    stay_set_a: assert property (err_flag && !clr_w |=> err_flag)
        else $error("status lost");
    no_spur_a: assert property (!err_flag && hready |=> !err_flag)
        else $error("spurious error");
    stat_rd_a: assert property (reg_sel && !reg_wr && reg_addr == AEC_OFS_STATUS
        |=> reg_rdata[31:3] == 29'h0 && reg_rdata[0] == $past(err_flag))
        else $error("status read wrong");
    attr_rd_a: assert property (reg_sel && !reg_wr && reg_addr == AEC_OFS_ATTR
        |=> reg_rdata[31:12] == 20'h0) else $error("attribute spare bits set");
endmodule // aec_monitor

bind aec_top aec_monitor #(.WDOG_CYCLES(WDOG_CYCLES)) u_mon (
    .clk(clk), .rst_b(rst_b), .hready(hready), .htrans(htrans), .hresp(hresp),
    .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .err_flag(err_flag));

// file: test/aec_ahb_model.sv
// aec_ahb_model: bus master and slave making observed traffic
`timescale 1ns/1ps
module aec_ahb_model
    import aec_pkg::*;
(
    input  wire logic        clk,     // clock
    output logic      [31:0] haddr,   // address
    output logic      [1:0]  htrans,  // type
    output logic             hwrite,  // direction
    output logic      [2:0]  hsize,   // size
    output logic      [2:0]  hburst,  // burst
    output logic      [3:0]  hmaster, // master
    output logic             hready,  // ready
    output logic      [1:0]  hresp,   // response
    output logic      [31:0] hwdata,  // write data
    output logic      [31:0] hrdata   // read data
);
    initial begin
        {haddr, htrans, hwrite, hsize, hburst, hmaster, hresp} = '0;
        {hwdata, hrdata} = '0;
        hready = 1'b1;
    end
    // k 0 okay, 1 error response, 2 nine wait states to trip the watchdog
    task automatic xfer(input int k, input logic [31:0] a, input logic [11:0] t,
                        input logic [31:0] wd, input logic [31:0] rd);
        @(posedge clk);
        haddr <= a;
        {hburst, htrans, hsize, hwrite, hmaster} <= {t[11:7], 1'b0, t[6:0]};
        @(posedge clk);
        htrans <= AEC_HTRANS_IDLE;
        hwdata <= wd;
        hrdata <= rd;
        hready <= (k == 0);
        hresp <= (k == 1) ? AEC_HRESP_ERROR : 2'h0;
        repeat (k == 2 ? 8 : 0) @(posedge clk);
        @(posedge clk);
        hready <= 1'b1;
        @(posedge clk);
        hresp <= 2'h0;
        // inverted so a stale data bus never looks valid
        hwdata <= ~wd;
        hrdata <= ~rd;
    endtask
endmodule // aec_ahb_model

// file: test/aec_top_tb_top.sv
// aec_top_tb_top: self-checking bench for the bus error capture block
`timescale 1ns/1ps
module aec_top_tb_top
    import aec_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        warm_rst = 1'b0;
    logic        reg_sel = 1'b0;
    logic        reg_wr = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] haddr, hwdata, hrdata, reg_rdata;
    logic [1:0]  htrans, hresp;
    logic [2:0]  hsize, hburst;
    logic [3:0]  hmaster;
    logic        hwrite, hready, err_flag;
    int          num_errors = 0;
    int          n_checks = 0;
    always #2.5 clk = ~clk;
    aec_ahb_model bfm (.clk(clk), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hburst(hburst), .hmaster(hmaster), .hready(hready),
        .hresp(hresp), .hwdata(hwdata), .hrdata(hrdata));
    aec_top #(.WDOG_CYCLES(8)) uut (.clk(clk), .rst_b(rst_b), .warm_rst(warm_rst),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hburst(hburst),
        .hmaster(hmaster), .hready(hready), .hresp(hresp), .hwdata(hwdata),
        .hrdata(hrdata), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .err_flag(err_flag));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_sel <= 1'b1;
        reg_wr <= w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_sel <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        #1 chk(reg_rdata, exp);
    endtask
    task automatic t_codes();
        logic [11:0] t;
        rd(8'h44, 32'h0);
        rd(AEC_OFS_STATUS, 32'h0);
        for (int i = 0; i < 16; i++) begin
            t = {1'b0, i[1:0], 1'b1, i[0], 2'(i % 3), i[0], i[3:0]};
            acc(1'b1, AEC_OFS_STATUS, 32'h1);
            rd(AEC_OFS_STATUS, 32'h0);
            bfm.xfer(1, 32'h1000_0000 + 32'(i), t, 32'(i), ~32'(i));
            rd(AEC_OFS_STATUS, 32'h1);
            rd(AEC_OFS_ATTR, {20'h0, t});
        end
    endtask
    task automatic t_capture();
        acc(1'b1, AEC_OFS_STATUS, 32'h1);
        bfm.xfer(1, 32'hCAFE_0123, 12'h535, 32'hA5A5_0F0F, 32'h1234_5678);
        bfm.xfer(1, 32'h0000_0040, 12'h180, 32'h0, 32'hFFFF_FFFF);
        rd(AEC_OFS_STATUS, 32'h3);
        rd(AEC_OFS_ADDR, 32'hCAFE_0123);
        rd(AEC_OFS_WDATA, 32'hA5A5_0F0F);
        rd(AEC_OFS_RDATA, 32'h1234_5678);
        rd(AEC_OFS_ATTR, 32'h535);
        acc(1'b1, AEC_OFS_STATUS, 32'hFFFF_FFFE);
        acc(1'b1, AEC_OFS_ADDR, 32'h0);
        rd(AEC_OFS_STATUS, 32'h3);
        rd(AEC_OFS_ADDR, 32'hCAFE_0123);
        @(posedge clk);
        warm_rst <= 1'b1;
        repeat (3) @(posedge clk);
        warm_rst <= 1'b0;
        rd(AEC_OFS_STATUS, 32'h3);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd(AEC_OFS_STATUS, 32'h0);
        rd(AEC_OFS_ADDR, 32'h0);
    endtask
    task automatic t_wdog();
        bfm.xfer(0, 32'h0000_1000, 12'h100, 32'h3, 32'h4);
        rd(AEC_OFS_STATUS, 32'h0);
        bfm.xfer(1, 32'h0000_2000, 12'h080, 32'h5, 32'h6);
        rd(AEC_OFS_STATUS, 32'h0);
        bfm.xfer(2, 32'h0BAD_0000, 12'h100, 32'h1, 32'h2);
        rd(AEC_OFS_STATUS, 32'h5);
        rd(AEC_OFS_ADDR, 32'h0BAD_0000);
        rd(AEC_OFS_WDATA, 32'h1);
        rd(AEC_OFS_ATTR, 32'h100);
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        t_codes();
        t_capture();
        t_wdog();
        end_of_test();
    end
    // whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        end_of_test();
    end
endmodule // aec_top_tb_top
